// >>> src/dbc_defines.svh
// dbc_defines.svh - divisor codes and timing counts for the dual bridge chopper control
// assumes a 10 MHz core clock; included by bare name
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define DBC_CLK_PERIOD_NS 100
`define DBC_DEADTIME_NS 2000
`define DBC_DEADTIME_CYC ((`DBC_DEADTIME_NS + `DBC_CLK_PERIOD_NS - 1) / `DBC_CLK_PERIOD_NS)
`define DBC_LATENCY_NS 2000
`define DBC_LATENCY_CYC (`DBC_LATENCY_NS / `DBC_CLK_PERIOD_NS)
// source-off interval is R times C; default 20 kohm * 1000 pF = 20000 ns
`define DBC_OFF_RES_OHM 20000
`define DBC_OFF_CAP_PF 1000
`define DBC_OFF_NS ((`DBC_OFF_RES_OHM * `DBC_OFF_CAP_PF) / 1000)
`define DBC_OFF_CYC (`DBC_OFF_NS / `DBC_CLK_PERIOD_NS)
// ----------------------------------------
// threshold divisors, in tenths
// ----------------------------------------
`define DBC_DIV_FULL 12'h064
`define DBC_DIV_TWO_THIRDS 12'h096
`define DBC_DIV_TWO_FIFTHS 12'h0f4
`define DBC_DIV_ZERO 12'h000

`endif

// >>> src/dbc_pkg.sv
// dbc_pkg.sv - types for the dual bridge chopper control
// assumes dbc_defines.svh is available on the include path
package dbc_pkg;
    // current level select code, {bit1, bit0}
    typedef enum logic [1:0] {
        LVL_FULL = 2'h0,
        LVL_TWO_THIRDS = 2'h1,
        LVL_TWO_FIFTHS = 2'h2,
        LVL_ZERO = 2'h3
    } dbc_level_type;

    // per bridge chopper state
    typedef enum logic [1:0] {
        ST_DEAD = 2'h0,
        ST_ON = 2'h1,
        ST_LATENCY = 2'h2,
        ST_OFF = 2'h3
    } dbc_state_type;
endpackage : dbc_pkg

// >>> src/dbc_bridge.sv
// dbc_bridge.sv - one full bridge: deadtime, trip latency and source-off one-shot
// assumes trip and thermal inputs already synchronised to core_clk
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_bridge
    import dbc_pkg::*;
#(
    parameter int DEAD_CYC = `DBC_DEADTIME_CYC,
    parameter int LAT_CYC = `DBC_LATENCY_CYC,
    parameter int OFF_CYC = `DBC_OFF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // host controls
    input wire logic direction,
    input wire logic levelSelectBit0,
    input wire logic levelSelectBit1,
    // sensing and protection
    input wire logic tripSync,
    input wire logic thermalOff,
    // driver enables
    output logic srcAEn,
    output logic srcBEn,
    output logic sinkAEn,
    output logic sinkBEn,
    output logic [11:0] thresholdDiv,
    output logic oneShotActive
);
    localparam int CW = 16;
    initial begin
        if (DEAD_CYC < 1 || LAT_CYC < 1 || OFF_CYC < 1 || OFF_CYC >= 2**CW || DEAD_CYC >= 2**CW)
            $error("dbc_bridge: counts out of range");
    end

    dbc_level_type level;
    dbc_state_type state_reg, state_next;
    logic [CW-1:0] count_reg, count_next;
    logic dirSeen_reg, dirSeen_next;
    logic disabled;
    logic srcAEn_next, srcBEn_next, sinkAEn_next, sinkBEn_next;
    logic [11:0] thresholdDiv_next;

    assign level = dbc_level_type'({levelSelectBit1, levelSelectBit0}); // [RQ8]
    assign disabled = (level == LVL_ZERO) || thermalOff; // [RQ9] [RQ14]

    // next state of the chopper sequencer
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        dirSeen_next = direction;
        if (direction != dirSeen_reg) begin
            state_next = ST_DEAD; // [RQ10]
            count_next = CW'(DEAD_CYC - 1);
        end else begin
            case (state_reg)
                ST_DEAD: begin
                    if (count_reg == '0)
                        state_next = ST_ON;
                    else
                        count_next = count_reg - 1'b1;
                end
                ST_ON: begin
                    if (tripSync && !disabled) begin
                        state_next = ST_LATENCY; // [RQ3] [RQ5]
                        count_next = CW'(LAT_CYC - 1);
                    end
                end
                ST_LATENCY: begin
                    if (count_reg == '0) begin
                        state_next = ST_OFF; // [RQ4]
                        count_next = CW'(OFF_CYC - 1);
                    end else
                        count_next = count_reg - 1'b1;
                end
                ST_OFF: begin
                    if (count_reg == '0)
                        state_next = ST_ON; // [RQ6]
                    else
                        count_next = count_reg - 1'b1;
                end
                default: state_next = ST_DEAD;
            endcase
        end
    end

    // driver enables from state, direction and level
    always_comb begin
        srcAEn_next = 1'b0;
        srcBEn_next = 1'b0;
        sinkAEn_next = 1'b0;
        sinkBEn_next = 1'b0;
        if (!disabled && state_next != ST_DEAD) begin
            sinkAEn_next = !direction; // [RQ15]
            sinkBEn_next = direction;
            srcAEn_next = direction && (state_next != ST_OFF); // [RQ3]
            srcBEn_next = !direction && (state_next != ST_OFF);
        end
        case (level)
            LVL_FULL: thresholdDiv_next = `DBC_DIV_FULL; // [RQ2]
            LVL_TWO_THIRDS: thresholdDiv_next = `DBC_DIV_TWO_THIRDS;
            LVL_TWO_FIFTHS: thresholdDiv_next = `DBC_DIV_TWO_FIFTHS;
            default: thresholdDiv_next = `DBC_DIV_ZERO;
        endcase
    end

    // registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= ST_DEAD;
            count_reg <= CW'(DEAD_CYC - 1);
            dirSeen_reg <= 1'b0;
            srcAEn <= 1'b0;
            srcBEn <= 1'b0;
            sinkAEn <= 1'b0;
            sinkBEn <= 1'b0;
            thresholdDiv <= `DBC_DIV_FULL;
            oneShotActive <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            dirSeen_reg <= dirSeen_next;
            srcAEn <= srcAEn_next;
            srcBEn <= srcBEn_next;
            sinkAEn <= sinkAEn_next;
            sinkBEn <= sinkBEn_next;
            thresholdDiv <= thresholdDiv_next;
            oneShotActive <= (state_next == ST_OFF);
        end
    end

    a_no_shoot: assert property (@(posedge core_clk) disable iff (!rstn)
        !(srcAEn && sinkAEn) && !(srcBEn && sinkBEn)) else $error("shoot-through"); // [RQ10]
    a_zero_off: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(level == LVL_ZERO) |-> !(srcAEn || srcBEn || sinkAEn || sinkBEn))
        else $error("zero level left a driver on"); // [RQ9]
    a_off_sink_on: assert property (@(posedge core_clk) disable iff (!rstn)
        oneShotActive && !$past(disabled) |-> (sinkAEn || sinkBEn) && !srcAEn && !srcBEn)
        else $error("off interval wrong drivers"); // [RQ3]
endmodule : dbc_bridge

// >>> src/dbc_top.sv
// dbc_top.sv - dual bridge chopper control, two independent bridges
// assumes trip and thermal pins asynchronous to core_clk; host pins too
//
// Functional notes
// RQ1 - each bridge regulates with its own one-shot
// RQ2 - current rises until threshold; full is ref/10
// RQ3 - trip turns off only source; sink stays
// RQ4 - off interval equals timing R times C
// RQ5 - about 2 us trip-to-turnoff latency
// RQ6 - source re-enabled after interval; cycle repeats
// RQ7 - user adds delay for capacitive spikes
// RQ8 - select decode: 100, 67, 41, 0 percent
// RQ9 - zero code turns all bridge drivers off
// RQ10 - direction change forces 2 us deadtime
// RQ11 - host half steps with 100/67 percent
// RQ12 - host quarter steps through five level pairs
// RQ13 - host may reduce hold, raise start current
// RQ14 - thermal off at 170, back at 145
// RQ15 - direction high: A high, B low
// RQ16 - counters for times; inputs synchronised first
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_top
    import dbc_pkg::*;
#(
    parameter int DEAD_CYC = `DBC_DEADTIME_CYC,
    parameter int LAT_CYC = `DBC_LATENCY_CYC,
    parameter int OFF_CYC = `DBC_OFF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // host controls, per bridge
    input wire logic [1:0] direction,
    input wire logic [1:0] levelSelectBit0,
    input wire logic [1:0] levelSelectBit1,
    // comparator trips and thermal flags (hot at 170, cool at 145)
    input wire logic [1:0] tripCurrent,
    input wire logic overTemp,
    input wire logic coolTemp,
    // drivers per bridge
    output logic [1:0] srcAEn,
    output logic [1:0] srcBEn,
    output logic [1:0] sinkAEn,
    output logic [1:0] sinkBEn,
    output logic [23:0] thresholdDiv,
    output logic [1:0] oneShotActive,
    output logic thermalOff
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] trip_meta_reg, trip_reg;
    logic [1:0] therm_meta_reg, therm_reg;
    logic [1:0] dir_meta_reg, dir_reg, b0_meta_reg, b0_reg, b1_meta_reg, b1_reg;
    logic thermalOff_next;
    // the trip-latency check looks back this many cycles
    localparam int TRIP_PAST = LAT_CYC + 1;

    // the off-length check looks back eight cycles, so shorter intervals are refused
    initial begin
        if (OFF_CYC < 8)
            $error("dbc_top: OFF_CYC below 8");
    end

    // two flops on every pin
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trip_meta_reg <= 2'h0;
            trip_reg <= 2'h0;
            therm_meta_reg <= 2'h0;
            therm_reg <= 2'h0;
            dir_meta_reg <= 2'h0;
            dir_reg <= 2'h0;
            b0_meta_reg <= 2'h3;
            b0_reg <= 2'h3;
            b1_meta_reg <= 2'h3;
            b1_reg <= 2'h3;
        end else begin
            trip_meta_reg <= tripCurrent; // [RQ16]
            trip_reg <= trip_meta_reg;
            therm_meta_reg <= {coolTemp, overTemp};
            therm_reg <= therm_meta_reg;
            dir_meta_reg <= direction;
            dir_reg <= dir_meta_reg;
            b0_meta_reg <= levelSelectBit0;
            b0_reg <= b0_meta_reg;
            b1_meta_reg <= levelSelectBit1;
            b1_reg <= b1_meta_reg;
        end
    end

    // ----------------------------------------
    // thermal hysteresis
    // ----------------------------------------
    // shut down at hot flag, release only when cool flag seen
    always_comb begin
        thermalOff_next = thermalOff;
        if (therm_reg[0])
            thermalOff_next = 1'b1; // [RQ14]
        else if (therm_reg[1])
            thermalOff_next = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn)
            thermalOff <= 1'b0;
        else
            thermalOff <= thermalOff_next;
    end

    // ----------------------------------------
    // two independent bridges
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bridge
            dbc_bridge #(
                .DEAD_CYC(DEAD_CYC),
                .LAT_CYC(LAT_CYC),
                .OFF_CYC(OFF_CYC)
            ) dbc_bridge_inst ( // [RQ1]
                .core_clk(core_clk),
                .rstn(rstn),
                .direction(dir_reg[gi]),
                .levelSelectBit0(b0_reg[gi]),
                .levelSelectBit1(b1_reg[gi]),
                .tripSync(trip_reg[gi]),
                .thermalOff(thermalOff_next),
                .srcAEn(srcAEn[gi]),
                .srcBEn(srcBEn[gi]),
                .sinkAEn(sinkAEn[gi]),
                .sinkBEn(sinkBEn[gi]),
                .thresholdDiv(thresholdDiv[gi*12 +: 12]),
                .oneShotActive(oneShotActive[gi])
            );
        end
    endgenerate

    a_thermal_kill: assert property (@(posedge core_clk) disable iff (!rstn)
        thermalOff |-> !(|srcAEn) && !(|srcBEn) && !(|sinkAEn) && !(|sinkBEn))
        else $error("driver on during thermal shutdown"); // [RQ14]
    a_trip_latency: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(oneShotActive[0]) |-> $past(trip_reg[0], TRIP_PAST))
        else $error("source off without trip latency"); // [RQ5]
    a_dir_polarity: assert property (@(posedge core_clk) disable iff (!rstn)
        srcAEn[0] |-> $past(dir_reg[0]) && sinkBEn[0]) else $error("bridge 0 polarity wrong"); // [RQ15]
    a_full_div: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(b0_reg[0] == 1'b0 && b1_reg[0] == 1'b0) |-> thresholdDiv[11:0] == 12'h064)
        else $error("full level divisor wrong"); // [RQ2]
    // a bridge 1 interval that ends without a direction change must have stood at least eight cycles
    a_off_length: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(oneShotActive[1]) && ($past(dir_reg[1]) == $past(dir_reg[1], 2)) |-> $past(oneShotActive[1], 8))
        else $error("off interval too short"); // [RQ4] [RQ6]
endmodule : dbc_top

// >>> bench/dbc_host_model.sv
// dbc_host_model.sv - host controller model driving direction and level pins
// assumes the bench picks the mode and step; outputs feed the block's pins
`timescale 1ns/1ps
module dbc_host_model
    import dbc_pkg::*;
(
    // sequence control from the bench
    input wire logic [1:0] mode,
    input wire logic [2:0] stepIdx,
    input wire logic [1:0] manDir,
    input wire logic [1:0] manSel0,
    input wire logic [1:0] manSel1,
    // pins toward the block
    output logic [1:0] direction,
    output logic [1:0] levelSelectBit0,
    output logic [1:0] levelSelectBit1
);
    logic [1:0] lvl0;
    logic [1:0] lvl1;

    // ----------------------------------------
    // step tables
    // ----------------------------------------
    // manual hold/start levels, half step or quarter step tables
    always_comb begin
        direction = manDir;
        lvl0 = {manSel1[0], manSel0[0]};
        lvl1 = {manSel1[1], manSel0[1]};
        if (mode == 2'h1) begin
            direction = {~(stepIdx[2] ^ stepIdx[1]), ~stepIdx[2]};
            lvl0 = stepIdx[0] ? LVL_TWO_THIRDS : (stepIdx[1] ? LVL_ZERO : LVL_FULL);
            lvl1 = stepIdx[0] ? LVL_TWO_THIRDS : (stepIdx[1] ? LVL_FULL : LVL_ZERO);
        end else if (mode == 2'h2) begin
            case (stepIdx)
                3'h0: {lvl0, lvl1} = {LVL_FULL, LVL_ZERO};
                3'h1: {lvl0, lvl1} = {LVL_FULL, LVL_TWO_FIFTHS};
                3'h2: {lvl0, lvl1} = {LVL_TWO_THIRDS, LVL_TWO_THIRDS};
                3'h3: {lvl0, lvl1} = {LVL_TWO_FIFTHS, LVL_FULL};
                default: {lvl0, lvl1} = {LVL_ZERO, LVL_FULL};
            endcase
        end
        levelSelectBit0 = {lvl1[0], lvl0[0]};
        levelSelectBit1 = {lvl1[1], lvl0[1]};
    end
endmodule : dbc_host_model

// >>> bench/dual_bridge_chopper_control_tb.sv
// dual_bridge_chopper_control_tb.sv - self-checking bench for dbc_top
// assumes short counts (2, 2, 8); inputs change at the falling edge
`timescale 1ns/1ps
module dual_bridge_chopper_control_tb;
    localparam int DEAD = 2;
    localparam int LAT = 2;
    localparam int OFF = 8;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [2:0] stepIdx = 3'h0;
    logic [1:0] manDir = 2'h3;
    logic [1:0] manSel0 = 2'h0;
    logic [1:0] manSel1 = 2'h0;
    logic [1:0] tripCurrent = 2'h0;
    logic overTemp = 1'b0;
    logic coolTemp = 1'b0;
    logic [1:0] direction, levelSelectBit0, levelSelectBit1;
    logic [1:0] srcAEn, srcBEn, sinkAEn, sinkBEn, oneShotActive;
    logic [23:0] thresholdDiv;
    logic thermalOff;
    int nMismatch = 0;
    int comparisons = 0;
    logic [11:0] levelDiv [4] = '{12'h064, 12'h096, 12'h0f4, 12'h000};
    logic [23:0] quarterDiv [5] = '{24'h000064, 24'h0f4064, 24'h096096, 24'h0640f4, 24'h064000};

    // ----------------------------------------
    // clock, block and host
    // ----------------------------------------
    // 10 MHz core clock
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    dbc_top #(.DEAD_CYC(DEAD), .LAT_CYC(LAT), .OFF_CYC(OFF)) dbc_top_inst (.core_clk(core_clk), .rstn(rstn),
        .direction(direction), .levelSelectBit0(levelSelectBit0), .levelSelectBit1(levelSelectBit1),
        .tripCurrent(tripCurrent), .overTemp(overTemp), .coolTemp(coolTemp), .srcAEn(srcAEn), .srcBEn(srcBEn),
        .sinkAEn(sinkAEn), .sinkBEn(sinkBEn), .thresholdDiv(thresholdDiv), .oneShotActive(oneShotActive),
        .thermalOff(thermalOff));
    dbc_host_model dbc_host_model_inst (.mode(mode), .stepIdx(stepIdx), .manDir(manDir), .manSel0(manSel0),
        .manSel1(manSel1), .direction(direction), .levelSelectBit0(levelSelectBit0),
        .levelSelectBit1(levelSelectBit1));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("counts: %0d compares, %0d mismatches", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task guard(input int i, input int lim);
        if (i >= lim) begin
            nMismatch++;
            $display("MISMATCH t=%0t wait ran out", $time);
            report_and_stop();
        end
    endtask : guard
    task wait_src(input logic [1:0] v);
        int i;
        for (i = 0; i < 200 && srcAEn !== v; i++) tick(1);
        guard(i, 200);
    endtask : wait_src

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_reset;
        chk(24'({srcAEn, srcBEn, sinkAEn, sinkBEn}), 24'h0, "reset enables");
        chk(thresholdDiv, 24'h064064, "reset divisor");
        chk(24'({oneShotActive, thermalOff}), 24'h0, "reset flags");
        $display("test_reset done");
    endtask : test_reset
    task test_polarity;
        int n;
        wait_src(2'h3);
        chk(24'({sinkAEn, srcBEn, srcAEn, sinkBEn}), 24'h00000f, "dir high");
        chk(thresholdDiv, 24'h064064, "full level");
        manDir = 2'h0;
        wait_src(2'h0);
        for (n = 0; n < 200 && srcBEn !== 2'h3; n++) tick(1);
        guard(n, 200);
        chk(24'(n >= DEAD), 24'h1, "deadtime");
        chk(24'({sinkAEn, srcBEn, srcAEn, sinkBEn}), 24'h0000f0, "dir low");
        manDir = 2'h3;
        wait_src(2'h3);
        $display("test_polarity done");
    endtask : test_polarity
    task test_levels;
        int c;
        for (c = 0; c < 4; c++) begin
            manSel0 = {2{c[0]}};
            manSel1 = {2{c[1]}};
            tick(5);
            chk(thresholdDiv, {2{levelDiv[c]}}, "level divisor");
            if (c == 3) chk(24'({srcAEn, srcBEn, sinkAEn, sinkBEn}), 24'h0, "zero code");
        end
        manSel0 = 2'h0;
        manSel1 = 2'h0;
        wait_src(2'h3);
        $display("test_levels done");
    endtask : test_levels
    task test_trip;
        int k, n, m;
        for (k = 0; k < 2; k++) begin
            tripCurrent = k[0] ? 2'h2 : 2'h1;
            for (n = 0; n < 100 && srcAEn[k] !== 1'b0; n++) tick(1);
            guard(n, 100);
            chk(24'(n >= LAT + 1 && n <= LAT + 4), 24'h1, "trip latency");
            chk(24'({sinkBEn, srcAEn, oneShotActive}), k[0] ? 24'h000036 : 24'h000039, "source off only");
            tripCurrent = 2'h0;
            for (m = 0; m < 300 && oneShotActive[k] === 1'b1; m++) tick(1);
            guard(m, 300);
            chk(24'(m), 24'(OFF), "off interval");
            tick(2);
            chk(24'(srcAEn), 24'h3, "source back");
        end
        $display("test_trip done");
    endtask : test_trip
    task test_thermal;
        int i;
        overTemp = 1'b1;
        for (i = 0; i < 50 && thermalOff !== 1'b1; i++) tick(1);
        guard(i, 50);
        tick(2);
        chk(24'({srcAEn, srcBEn, sinkAEn, sinkBEn}), 24'h0, "hot drivers off");
        overTemp = 1'b0;
        tick(10);
        chk(24'(thermalOff), 24'h1, "hysteresis");
        coolTemp = 1'b1;
        for (i = 0; i < 50 && thermalOff !== 1'b0; i++) tick(1);
        guard(i, 50);
        coolTemp = 1'b0;
        wait_src(2'h3);
        chk(24'(sinkBEn), 24'h3, "drivers back");
        $display("test_thermal done");
    endtask : test_thermal
    task test_sequences;
        int i;
        mode = 2'h1;
        for (i = 0; i < 8; i++) begin
            stepIdx = 3'(i);
            tick(5);
            chk(thresholdDiv, i[0] ? 24'h096096 : (i[1] ? 24'h064000 : 24'h000064), "half step");
        end
        mode = 2'h2;
        for (i = 0; i < 5; i++) begin
            stepIdx = 3'(i);
            tick(5);
            chk(thresholdDiv, quarterDiv[i], "quarter step");
        end
        mode = 2'h0;
        $display("test_sequences done");
    endtask : test_sequences

    // main sequence: reset for 8 cycles, then each scenario
    initial begin
        tick(8);
        test_reset();
        rstn = 1'b1;
        test_polarity();
        test_levels();
        test_trip();
        test_thermal();
        test_sequences();
        report_and_stop();
    end
endmodule : dual_bridge_chopper_control_tb
